// *** shared/pfb_pkg.sv ***
// Shared constants, register map and pin carrier types for the parallel flash bus controller.
//
// Contract
// - Commands need write and select low, gate high.
// - Bypass mode programs with two writes, not four.
// - Reads during operations return status on low byte.
// - Host restarts an operation a clear pulse aborted; pfb_host only sets the aborted status bit and leaves the restart to software.
package pfb_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ           = 200;
    localparam int T_WE_NS           = 50;
    localparam int T_CE_NS           = 100;
    localparam int T_RP_NS           = 500;
    localparam int T_READY_NS        = 20000;
    localparam int T_READY_IDLE_NS   = 500;
    localparam int WE_CYC            = (T_WE_NS * CLK_MHZ + 999) / 1000;
    localparam int RD_CYC            = (T_CE_NS * CLK_MHZ + 999) / 1000;
    localparam int CLR_CYC           = (T_RP_NS * CLK_MHZ + 999) / 1000;
    localparam int READY_CYC         = (T_READY_NS * CLK_MHZ) / 1000;
    localparam int READY_IDLE_CYC    = (T_READY_IDLE_NS * CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------
    // Register map (byte offsets) and fields
    // ------------------------------------------------------------
    localparam logic [4:0] REG_CTRL   = 5'h00;
    localparam logic [4:0] REG_ADDR   = 5'h04;
    localparam logic [4:0] REG_WDATA  = 5'h08;
    localparam logic [4:0] REG_STATUS = 5'h0c;
    localparam logic [4:0] REG_RDATA  = 5'h10;
    localparam logic [4:0] REG_SECTOR = 5'h14;
    localparam int CTRL_OP_LSB   = 0;
    localparam int CTRL_WORD_BIT = 4;
    localparam logic [1:0] OP_READ  = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_CLEAR = 2'h2;
    localparam int ST_BUSY     = 0;
    localparam int ST_PROGRESS = 1;
    localparam int ST_ABORTED  = 2;
    localparam int ST_TIMEOUT  = 3;
    localparam logic RST_WORD_MODE = 1'b1;

    // ------------------------------------------------------------
    // Flash control pins
    // ------------------------------------------------------------
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic reset_n;
        logic byte_n;
    } pfb_ctl_t;

    localparam pfb_ctl_t CTL_RESET = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                       reset_n: 1'b1, byte_n: RST_WORD_MODE};

endpackage

// *** rtl/pfb_host.sv ***
// Host-side controller driving a parallel NOR flash from Avalon-MM registers.
`timescale 1ns/1ps
`default_nettype none
module pfb_host #(
    parameter bit TOP_BOOT = 1'b1
) (
    // Clock and reset.
    input  wire logic               CLK,
    input  wire logic               RST,
    // Avalon-MM slave.
    input  wire logic [4:0]         AVS_ADDRESS,
    input  wire logic               AVS_READ,
    input  wire logic               AVS_WRITE,
    input  wire logic [31:0]        AVS_WRITEDATA,
    output var  logic [31:0]        AVS_READDATA,
    output var  logic               AVS_WAITREQUEST,
    // Flash pins.
    output var  pfb_pkg::pfb_ctl_t  FL_CTL,
    output var  logic [18:0]        FL_ADDR,
    output var  logic [15:0]        FL_DQ_OUT,
    output var  logic [15:0]        FL_DQ_OE,
    input  wire logic [15:0]        FL_DQ_IN,
    input  wire logic               OP_PROGRESS_N
);
    import pfb_pkg::*;

    typedef enum {S_IDLE, S_RD, S_RD_CAP, S_WR, S_WR_REC, S_CLR, S_CLR_WAIT} pfb_state_t;

    pfb_state_t  state;
    pfb_state_t  next_state;
    logic [15:0] cnt;
    logic        word_mode;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        aborted;
    logic        timeout;
    logic        was_busy;
    logic [1:0]  op;
    logic        bus_take;
    logic        go;
    logic [4:0]  sector;

    // ------------------------------------------------------------
    // Sector decode
    // ------------------------------------------------------------
    // Maps A18:A12 to a sector index; lower bits never matter.
    function automatic logic [4:0] sector_of(input logic [6:0] a);
        logic [4:0] s;
        s = 5'h00;
        if (TOP_BOOT) begin
            if (a[6:3] != 4'hf) s = {1'b0, a[6:3]};
            else if (!a[2]) s = 5'h0f;
            else if (!a[1]) s = 5'h10 + {4'h0, a[0]};
            else s = 5'h12;
        end else begin
            if (a[6:3] != 4'h0) s = {1'b0, a[6:3]} + 5'h03;
            else if (a[2]) s = 5'h03;
            else if (a[1]) s = 5'h01 + {4'h0, a[0]};
            else s = 5'h00;
        end
        return s;
    endfunction

    // Byte mode takes A18:A12 from the upper bits of the byte address.
    assign sector = sector_of(word_mode ? addr[18:12] : addr[19:13]);

    // ------------------------------------------------------------
    // Avalon slave
    // ------------------------------------------------------------
    // A request is taken on the edge at which waitrequest is seen low.
    assign bus_take = (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
    assign go       = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == REG_CTRL && state == S_IDLE;
    assign op       = AVS_WRITEDATA[CTRL_OP_LSB +: 2];

    // Waitrequest drops for one cycle, one edge after a request appears.
    always_ff @(posedge CLK) begin
        if (RST) begin
            AVS_WAITREQUEST <= 1'b1;
        end else if (!AVS_WAITREQUEST) begin
            AVS_WAITREQUEST <= 1'b1;
        end else if (AVS_READ || AVS_WRITE) begin
            AVS_WAITREQUEST <= 1'b0;
        end
    end

    // Read data is formed together with the waitrequest drop.
    always_ff @(posedge CLK) begin
        if (RST) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (AVS_READ && AVS_WAITREQUEST) begin
            case (AVS_ADDRESS)
                REG_CTRL:   AVS_READDATA <= {27'h0, word_mode, 4'h0};
                REG_ADDR:   AVS_READDATA <= {12'h000, addr};
                REG_WDATA:  AVS_READDATA <= {16'h0000, wdata};
                REG_STATUS: AVS_READDATA <= {28'h0, timeout, aborted, OP_PROGRESS_N,
                                             state != S_IDLE};
                REG_RDATA:  AVS_READDATA <= {16'h0000, rdata};
                REG_SECTOR: AVS_READDATA <= {27'h0, sector};
                default:    AVS_READDATA <= 32'h0000_0000;
            endcase
        end
    end

    // Setup registers change only while idle, so pins stay stable mid cycle.
    always_ff @(posedge CLK) begin
        if (RST) begin
            word_mode <= RST_WORD_MODE;
            addr      <= 20'h00000;
            wdata     <= 16'h0000;
        end else if (bus_take && AVS_WRITE && state == S_IDLE) begin
            case (AVS_ADDRESS)
                REG_CTRL:  word_mode <= AVS_WRITEDATA[CTRL_WORD_BIT];
                REG_ADDR:  addr <= AVS_WRITEDATA[19:0];
                REG_WDATA: wdata <= AVS_WRITEDATA[15:0];
                default:   word_mode <= word_mode;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------
    // Chooses the next bus phase; each phase lasts its timing count.
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (go && op == OP_READ) next_state = S_RD;
                else if (go && op == OP_WRITE) next_state = S_WR;
                else if (go && op == OP_CLEAR) next_state = S_CLR;
            end
            S_RD:     if (cnt == 16'(RD_CYC - 1)) next_state = S_RD_CAP;
            S_RD_CAP: next_state = S_IDLE;
            S_WR:     if (cnt == 16'(WE_CYC - 1)) next_state = S_WR_REC;
            S_WR_REC: next_state = S_IDLE;
            S_CLR:    if (cnt == 16'(CLR_CYC - 1)) next_state = S_CLR_WAIT;
            S_CLR_WAIT: begin
                if ((cnt >= 16'(READY_IDLE_CYC - 1) && OP_PROGRESS_N) ||
                    cnt == 16'(READY_CYC - 1)) next_state = S_IDLE;
            end
            default:  next_state = S_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge CLK) begin
        if (RST) state <= S_IDLE;
        else state <= next_state;
    end

    // Phase counter restarts on every change of phase.
    always_ff @(posedge CLK) begin
        if (RST || next_state != state) cnt <= 16'h0000;
        else cnt <= cnt + 16'h0001;
    end

    // Captures array, identification or status data while the gate is low.
    always_ff @(posedge CLK) begin
        if (RST) rdata <= 16'h0000;
        else if (state == S_RD_CAP) rdata <= word_mode ? FL_DQ_IN : {8'h00, FL_DQ_IN[7:0]};
    end

    // Clear bookkeeping: busy at pulse start means an operation was cut off.
    always_ff @(posedge CLK) begin
        if (RST) begin
            was_busy <= 1'b0;
            aborted  <= 1'b0;
            timeout  <= 1'b0;
        end else if (go) begin
            was_busy <= 1'b0;
            aborted  <= 1'b0;
            timeout  <= 1'b0;
        end else if (state == S_IDLE && next_state == S_IDLE) begin
            was_busy <= was_busy;
        end else if (state == S_CLR && cnt == 16'h0000) begin
            was_busy <= !OP_PROGRESS_N;
            aborted  <= !OP_PROGRESS_N;
        end else if (state == S_CLR_WAIT && next_state == S_IDLE && !OP_PROGRESS_N) begin
            timeout  <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Flash pins
    // ------------------------------------------------------------
    // Pins follow the coming phase; outside cycles the part sits in standby.
    always_ff @(posedge CLK) begin
        if (RST) begin
            FL_CTL <= CTL_RESET;
        end else begin
            FL_CTL.ce_n    <= next_state inside {S_IDLE, S_CLR, S_CLR_WAIT};
            FL_CTL.oe_n    <= !(next_state inside {S_RD, S_RD_CAP});
            FL_CTL.we_n    <= next_state != S_WR;
            FL_CTL.reset_n <= next_state != S_CLR;
            FL_CTL.byte_n  <= word_mode;
        end
    end

    // Address held after each cycle so the part may sleep on it.
    always_ff @(posedge CLK) begin
        if (RST) FL_ADDR <= 19'h00000;
        else FL_ADDR <= word_mode ? addr[18:0] : addr[19:1];
    end

    // Write data stays driven one cycle past the rising write strobe.
    always_ff @(posedge CLK) begin
        if (RST) begin
            FL_DQ_OUT <= 16'h0000;
            FL_DQ_OE  <= 16'h0000;
        end else begin
            FL_DQ_OUT <= {word_mode ? wdata[15] : addr[0], wdata[14:0]};
            if (next_state inside {S_WR, S_WR_REC}) begin
                FL_DQ_OE <= word_mode ? 16'hffff : 16'h80ff;
            end else if (next_state inside {S_RD, S_RD_CAP}) begin
                FL_DQ_OE <= word_mode ? 16'h0000 : 16'h8000;
            end else begin
                FL_DQ_OE <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_WRITE_LEVELS: assert property (@(posedge CLK) disable iff (RST)
        !FL_CTL.we_n |-> !FL_CTL.ce_n && FL_CTL.oe_n)
        else $error("Write strobe low without select low and gate high.");
    AST_GATE_NO_DRIVE: assert property (@(posedge CLK) disable iff (RST)
        !FL_CTL.oe_n |-> (FL_DQ_OE[14:0] == 15'h0000) && FL_CTL.we_n)
        else $error("Host drives data while the gate is low.");
    AST_BYTE_UPPER: assert property (@(posedge CLK) disable iff (RST)
        !FL_CTL.byte_n && (!FL_CTL.oe_n || !FL_CTL.we_n) |-> FL_DQ_OE[15] && FL_DQ_OE[14:8] == 7'h00)
        else $error("Byte mode upper lanes wrong.");
    AST_STANDBY_IDLE: assert property (@(posedge CLK) disable iff (RST)
        state == S_IDLE && $past(state) == S_IDLE |-> FL_CTL.ce_n && FL_CTL.reset_n)
        else $error("Idle bus is not in standby.");
    AST_READ_ACCESS: assert property (@(posedge CLK) disable iff (RST)
        state == S_RD_CAP |-> !$past(FL_CTL.oe_n, RD_CYC) && !$past(FL_CTL.ce_n, RD_CYC))
        else $error("Read captured before select access time.");
    AST_CLEAR_WIDTH: assert property (@(posedge CLK) disable iff (RST)
        $rose(FL_CTL.reset_n) |-> $past(state) == S_CLR && $past(cnt) == 16'(CLR_CYC - 1))
        else $error("Clear pulse width wrong.");
    AST_DATA_HOLD: assert property (@(posedge CLK) disable iff (RST)
        $rose(FL_CTL.we_n) |-> FL_DQ_OE[0] && !FL_CTL.ce_n ##1 FL_CTL.ce_n)
        else $error("Write data not held past the strobe.");
    AST_READY_BOUND: assert property (@(posedge CLK) disable iff (RST)
        state == S_CLR_WAIT |-> cnt < 16'(READY_CYC))
        else $error("Ready wait exceeded.");
    AST_IDLE_WAIT: assert property (@(posedge CLK) disable iff (RST)
        state == S_CLR_WAIT && next_state == S_IDLE |-> cnt >= 16'(READY_IDLE_CYC - 1))
        else $error("Clear left before idle ready time.");
    AST_ONE_ANSWER: assert property (@(posedge CLK) disable iff (RST)
        !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("Waitrequest low for more than one cycle.");

endmodule // pfb_host
`default_nettype wire

// *** testbench/pfb_flash_model.sv ***
// Behavioural model of the parallel NOR flash that the host controller drives.
`timescale 1ns/1ps
`default_nettype none
module pfb_flash_model
#(
    parameter int         BUSY_CYC = 200,
    parameter int         RDY_CYC  = 300,
    parameter int         ACC_NS   = 60,
    parameter logic [7:0] ID_CODE  = 8'h3c, // Arbitrary identification value.
    parameter logic [7:0] ST_CODE  = 8'h80
) (
    // Timer clock and host pins.
    input  wire logic              clk,
    input  wire pfb_pkg::pfb_ctl_t ctl,
    input  wire logic [18:0]       addr,
    input  wire logic [15:0]       dq,
    // Device outputs.
    output var  logic [15:0]       dq_out,
    output var  logic [15:0]       dq_en,
    output var  logic              busy_n
);
    import pfb_pkg::*;
    logic [15:0] mem [256];
    logic [15:0] pend_dat;
    logic [7:0]  pend_idx;
    logic [7:0]  idx;
    logic        pend_ok;
    logic        pend_er;
    logic        byp;
    int          st;
    int          busy;
    wire  [15:0] rd_val;

    // Erased array, array-read mode at power-up.
    initial begin
        foreach (mem[i]) mem[i] = 16'hffff;
        st = 0;
        busy = 0;
        byp = 1'b0;
        pend_ok = 1'b0;
        pend_er = 1'b0;
    end

    // Byte mode takes its lowest address bit from DQ15.
    assign idx = ctl.byte_n ? addr[7:0] : {addr[6:0], dq[15]};

    // Command cycles are latched as the write strobe rises.
    always @(posedge ctl.we_n) begin
        if (!ctl.ce_n && ctl.oe_n && ctl.reset_n && busy == 0) begin
            case (st)
                3: begin
                    pend_idx = idx;
                    pend_dat = ctl.byte_n ? dq : {8'h00, dq[7:0]};
                    pend_ok = 1'b1;
                    busy = BUSY_CYC;
                    st = byp ? 5 : 0;
                end
                1: st = (addr == 19'h2aa && dq[7:0] == 8'h55) ? 2 : 0;
                2: begin
                    byp = (addr == 19'h555 && dq[7:0] == 8'h20);
                    st = 0;
                    if (addr == 19'h555) begin
                        case (dq[7:0])
                            8'ha0:   st = 3;
                            8'h90:   st = 4;
                            8'h80:   st = 6;
                            8'h20:   st = 5;
                            default: st = 0;
                        endcase
                    end
                end
                6: st = (addr == 19'h555 && dq[7:0] == 8'haa) ? 7 : 0;
                7: st = (addr == 19'h2aa && dq[7:0] == 8'h55) ? 8 : 0;
                8: begin
                    // Chip erase, or erase of the one modelled sector (upper bits only).
                    pend_er = (dq[7:0] == 8'h10 && addr == 19'h555) ||
                              (dq[7:0] == 8'h30 && addr[18:15] == 4'h0);
                    pend_ok = 1'b0;
                    busy = (dq[7:0] == 8'h10 || dq[7:0] == 8'h30) ? BUSY_CYC : 0;
                    st = 0;
                end
                5: begin
                    byp = dq[7:0] != 8'h90;
                    st = dq[7:0] == 8'ha0 ? 3 : byp ? 5 : 0;
                end
                default: st = (addr == 19'h555 && dq[7:0] == 8'haa) ? 1 : 0;
            endcase
        end
    end

    // Operation timer; a clear aborts the pending write and stretches busy.
    always @(posedge clk) begin
        if (!ctl.reset_n) begin
            st = 0;
            byp = 1'b0;
            pend_ok = 1'b0;
            pend_er = 1'b0;
            if (busy > 0) busy = RDY_CYC;
        end else if (busy > 0) begin
            if (busy == 1 && pend_ok) mem[pend_idx] = pend_dat;
            if (busy == 1 && pend_er) foreach (mem[i]) mem[i] = 16'hffff;
            if (busy == 1) {pend_ok, pend_er} = 2'h0;
            busy = busy - 1;
        end
    end

    // Status while busy, codes in identification mode, array data otherwise.
    assign busy_n = (busy == 0);
    assign #(ACC_NS) rd_val = !busy_n ? {8'h00, ST_CODE} : st == 4 ? {8'h00, ID_CODE} : mem[idx];
    assign dq_out = ctl.byte_n ? rd_val : {8'h00, rd_val[7:0]};
    assign dq_en = {{8{ctl.byte_n}}, 8'hff} & {16{!ctl.ce_n && !ctl.oe_n && ctl.reset_n}};
endmodule // pfb_flash_model
`default_nettype wire

// *** testbench/pfb_host_tb_top.sv ***
// Self-checking testbench for the parallel flash host controller.
`timescale 1ns/1ps
`default_nettype none
module pfb_host_tb_top;
    import pfb_pkg::*;
    logic        clk;
    logic        rst;
    logic [4:0]  av_addr;
    logic        av_rd;
    logic        av_wr;
    logic [31:0] av_wdata;
    logic [31:0] av_rdata;
    logic        av_wait;
    pfb_ctl_t    fl_ctl;
    logic [18:0] fl_addr;
    logic [15:0] h_out, h_oe, d_out, d_en, flt, dq;
    logic        busy_n;
    logic        wm;
    logic [31:0] q;
    int          n_mismatch;
    int          tests_run;
    logic [18:0] sec_a [7] = '{19'h00000, 19'h0ffff, 19'h77fff, 19'h78000, 19'h7c000, 19'h7d000, 19'h7e123};
    logic [4:0]  sec_n [7] = '{5'h00, 5'h01, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12};

    // Clock, and a changing pattern for a line that nobody drives.
    always #2.5 clk = ~clk;
    always @(posedge clk) flt <= ~flt;
    assign dq = (h_oe & h_out) | (~h_oe & d_en & d_out) | (~h_oe & ~d_en & flt);

    pfb_host #(.TOP_BOOT(1'b1)) pfb_host_i (.CLK(clk), .RST(rst), .AVS_ADDRESS(av_addr),
        .AVS_READ(av_rd), .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wdata), .AVS_READDATA(av_rdata),
        .AVS_WAITREQUEST(av_wait), .FL_CTL(fl_ctl), .FL_ADDR(fl_addr), .FL_DQ_OUT(h_out),
        .FL_DQ_OE(h_oe), .FL_DQ_IN(dq), .OP_PROGRESS_N(busy_n));
    pfb_flash_model pfb_flash_model_i (.clk(clk), .ctl(fl_ctl), .addr(fl_addr), .dq(dq),
        .dq_out(d_out), .dq_en(d_en), .busy_n(busy_n));

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low.
    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        av_addr <= a;
        av_wr <= wr;
        av_rd <= !wr;
        av_wdata <= d;
        do @(posedge clk); while (av_wait !== 1'b0);
        q = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask

    task automatic poll(input int b, input logic lvl);
        av(1'b0, REG_STATUS, 32'h0);
        for (int k = 0; k < 3000 && q[b] !== lvl; k++) av(1'b0, REG_STATUS, 32'h0);
    endtask

    task automatic op(input logic [1:0] o, input logic [19:0] a, input logic [15:0] d);
        av(1'b1, REG_ADDR, {12'h0, a});
        av(1'b1, REG_WDATA, {16'h0, d});
        av(1'b1, REG_CTRL, {27'h0, wm, 2'h0, o});
        poll(ST_BUSY, 1'b0);
    endtask

    task automatic cmd(input logic [19:0] a, input logic [7:0] d);
        op(OP_WRITE, a, {8'h00, d});
    endtask

    task automatic unlock(input logic [7:0] c);
        cmd(20'h555, 8'haa);
        cmd(20'h2aa, 8'h55);
        cmd(20'h555, c);
    endtask

    // Six-cycle erase sequence, then wait for the busy pin to clear.
    task automatic erase(input logic [19:0] a, input logic [7:0] c);
        unlock(8'h80);
        cmd(20'h555, 8'haa);
        cmd(20'h2aa, 8'h55);
        cmd(a, c);
        poll(ST_PROGRESS, 1'b1);
    endtask

    task automatic rd(input logic [19:0] a, input logic [31:0] exp);
        op(OP_READ, a, 16'h0);
        av(1'b0, REG_RDATA, 32'h0);
        chk("rdata", exp, q);
    endtask

    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {av_addr, av_rd, av_wr, av_wdata} = '0;
        flt = 16'h5a5a;
        wm = 1'b1;
        n_mismatch = 0;
        tests_run = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        av(1'b0, REG_STATUS, 32'h0);
        chk("status", 32'h2, q);
        av(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", 32'h10, q);
        av(1'b0, 5'h18, 32'h0);
        chk("unmapped", 32'h0, q);
        rd(20'h10, 32'hffff);
        unlock(8'ha0);
        op(OP_WRITE, 20'h10, 16'h1234);
        rd(20'h10, 32'h0080);
        poll(ST_PROGRESS, 1'b1);
        rd(20'h10, 32'h1234);
        cmd(20'h555, 8'haa);
        cmd(20'h123, 8'h55);
        cmd(20'h2aa, 8'h55);
        cmd(20'h555, 8'ha0);
        op(OP_WRITE, 20'h11, 16'habcd);
        rd(20'h11, 32'hffff);
        unlock(8'h90);
        rd(20'h0, 32'h003c);
        cmd(20'h0, 8'hf0);
        rd(20'h10, 32'h1234);
        unlock(8'h20);
        cmd(20'h0, 8'ha0);
        op(OP_WRITE, 20'h20, 16'h5678);
        poll(ST_PROGRESS, 1'b1);
        rd(20'h20, 32'h5678);
        wm = 1'b0;
        cmd(20'h0, 8'ha0);
        op(OP_WRITE, 20'h61, 16'h009c);
        poll(ST_PROGRESS, 1'b1);
        rd(20'h61, 32'h009c);
        wm = 1'b1;
        cmd(20'h0, 8'h90);
        cmd(20'h0, 8'h00);
        unlock(8'ha0);
        op(OP_WRITE, 20'h30, 16'h1111);
        op(OP_CLEAR, 20'h0, 16'h0);
        av(1'b0, REG_STATUS, 32'h0);
        chk("status", 32'h6, q);
        rd(20'h30, 32'hffff);
        unlock(8'ha0);
        op(OP_WRITE, 20'h30, 16'h1111);
        poll(ST_PROGRESS, 1'b1);
        rd(20'h30, 32'h1111);
        op(OP_CLEAR, 20'h0, 16'h0);
        av(1'b0, REG_STATUS, 32'h0);
        chk("status", 32'h2, q);
        erase(20'h40000, 8'h30);
        rd(20'h10, 32'h1234);
        erase(20'h555, 8'h10);
        rd(20'h10, 32'hffff);
        unlock(8'ha0);
        op(OP_WRITE, 20'h20, 16'h4321);
        poll(ST_PROGRESS, 1'b1);
        rd(20'h20, 32'h4321);
        erase(20'h07fff, 8'h30);
        rd(20'h20, 32'hffff);
        for (int i = 0; i < 7; i++) begin
            av(1'b1, REG_ADDR, {13'h0, sec_a[i]});
            av(1'b0, REG_SECTOR, 32'h0);
            chk("sector", {27'h0, sec_n[i]}, q);
        end
        complete_run();
    end

    // Watchdog against a hang.
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
endmodule // pfb_host_tb_top
`default_nettype wire
